/* hdl/sfi_cfg.svh */
// Constants for the serial flash interface state block
`ifndef SFI_CFG_SVH
`define SFI_CFG_SVH
`define SFI_CLK_MHZ 125
`define SFI_T_PU_US 300
`define SFI_T_PD_US 10
`define SFI_T_RP_NS 200
`define SFI_T_RPH_US 35
`define SFI_T_RH_NS 50
`define SFI_PU_CYC (`SFI_T_PU_US * `SFI_CLK_MHZ)
`define SFI_PD_CYC (`SFI_T_PD_US * `SFI_CLK_MHZ)
`define SFI_RP_CYC ((`SFI_T_RP_NS * `SFI_CLK_MHZ + 999) / 1000)
`define SFI_RPH_CYC (`SFI_T_RPH_US * `SFI_CLK_MHZ)
`define SFI_RH_CYC ((`SFI_T_RH_NS * `SFI_CLK_MHZ + 999) / 1000)
`define SFI_INSTR_BITS 8
`define SFI_CFG_QUAD_BIT 1
`define SFI_CFG_LAT_LSB 6
`define SFI_CFG_LAT_MSB 7
`define SFI_CFG_RESET 8'h00
`endif

/* hdl/sfi_pkg.sv */
// Types for the serial flash interface state block
package sfi_pkg;
   // Power and reset states of the core side
   typedef enum logic [2:0] {
      PWR_OFF = 3'b000,
      PWR_LOWPROT = 3'b001,
      PWR_COLD = 3'b010,
      PWR_WARM = 3'b011,
      PWR_READY = 3'b100
   } sfi_pwr_t;
   // Link phase states
   typedef enum logic [3:0] {
      PH_STANDBY = 4'h0,
      PH_INSTR = 4'h1,
      PH_IN_SINGLE = 4'h2,
      PH_IN_DUAL = 4'h3,
      PH_IN_QUAD = 4'h4,
      PH_QPP_ADDR = 4'h5,
      PH_LATENCY = 4'h6,
      PH_OUT_SINGLE = 4'h7,
      PH_OUT_DUAL = 4'h8,
      PH_OUT_QUAD = 4'h9
   } sfi_phase_t;
   // Phase request from the command decoder
   typedef struct packed {
      logic [3:0] phase;
      logic ddr;
      logic lat_drive;
   } sfi_req_t;
   // Pin bundle for the four data lines
   typedef struct packed {
      logic [3:0] val;
      logic [3:0] oe;
   } sfi_dq_t;
endpackage : sfi_pkg

/* hdl/sfi_iface.sv */
// Interface state block of a serial flash: power, reset and line direction
//
// Behaviour
// - Supply low: off, inert, output floating
// - Below cut-off supply: reject every command
// - Low long enough then rising: cold reset
// - Power-up interval silent, then standby
// - Warm reset after long enough reset pulse
// - Standby after processing and release hold
// - Select high: standby, outputs float
// - Select falling enters instruction capture
// - Single latency: ignore input, no drive
// - Dual latency: lines zero, one unused
// - Quad latency: all four lines unused
// - DDR latency: drive valid or float
// - DDR single output: line one driven, lines zero, two, three float
// - DDR dual output: lines zero, one driven
// - Quad output drives four lines until deselect
// - Eight instruction bits, MSB first, rising edge
// - Pause pin freezes command without quad mode or DDR
// - Latency count from configuration latency code
`include "sfi_cfg.svh"
`timescale 1ns/1ps
`default_nettype none
module sfi_iface #(
   parameter int PU_CYC = `SFI_PU_CYC,
   parameter int PD_CYC = `SFI_PD_CYC,
   parameter int RPH_CYC = `SFI_RPH_CYC,
   parameter int CNT_W = 16
) (
   // Core clock and reset
   input wire logic core_clk_i,
   input wire logic rst_n_i,
   // Supply monitor levels (asynchronous)
   input wire logic vcc_low_i,
   input wire logic vcc_cutoff_i,
   input wire logic vcc_min_i,
   // Hardware reset pin, active low (asynchronous)
   input wire logic hw_rst_n_i,
   // Link pins
   input wire logic sck_i,
   input wire logic cs_n_i,
   input wire logic [3:0] dq_i,
   output logic [3:0] dq_o,
   output logic [3:0] dq_oe_o,
   // Configuration bits from the decoder side
   input wire logic [7:0] configuration_reg_i,
   // Phase request and read data, sck domain logic source
   input wire sfi_pkg::sfi_req_t req_i,
   input wire logic req_valid_i,
   input wire logic [3:0] rd_nib_i,
   // Captured instruction and status
   output logic [7:0] instr_o,
   output logic instr_valid_o,
   output logic cmd_enable_o,
   output logic [2:0] pwr_state_o,
   output logic [3:0] phase_o,
   output logic [1:0] lat_code_o
);
   initial begin
      if (CNT_W < 8 || PU_CYC >= (1 << CNT_W) || RPH_CYC >= (1 << CNT_W)
          || PD_CYC >= (1 << CNT_W)) begin
         $error("sfi_iface: counter width too small");
      end
   end
   localparam logic [CNT_W-1:0] PU_N = CNT_W'(PU_CYC);
   localparam logic [CNT_W-1:0] PD_N = CNT_W'(PD_CYC);
   localparam logic [CNT_W-1:0] RPH_N = CNT_W'(RPH_CYC);
   localparam logic [CNT_W-1:0] RP_N = CNT_W'(`SFI_RP_CYC);
   localparam logic [CNT_W-1:0] RH_N = CNT_W'(`SFI_RH_CYC);

   // Two-stage synchronisers for the asynchronous core-side levels
   logic [4:0] sync1_q;
   logic [4:0] sync2_q;
   always_ff @(posedge core_clk_i) begin
      sync1_q <= {cs_n_i, hw_rst_n_i, vcc_min_i, vcc_cutoff_i, vcc_low_i};
      sync2_q <= sync1_q;
   end
   wire s_low = sync2_q[0];
   wire s_cut = sync2_q[1];
   wire s_min = sync2_q[2];
   wire s_rstn = sync2_q[3];

   // Power and reset sequencer
   sfi_pkg::sfi_pwr_t pwr_q, pwr_d;
   logic [CNT_W-1:0] cnt_q, cnt_d;
   logic [CNT_W-1:0] lowcnt_q;
   logic [CNT_W-1:0] rpcnt_q;
   logic [CNT_W-1:0] rhcnt_q;
   logic pd_met_q;
   wire pd_done = (lowcnt_q >= PD_N);
   wire rp_done = (rpcnt_q >= RP_N);
   wire rh_done = (rhcnt_q >= RH_N);

   // Supply-low time, reset-low time and release-hold time counters
   always_ff @(posedge core_clk_i) begin
      if (!rst_n_i) begin
         lowcnt_q <= '0;
         rpcnt_q <= '0;
         rhcnt_q <= '0;
         pd_met_q <= 1'b0;
      end else begin
         lowcnt_q <= s_low ? (pd_done ? lowcnt_q : lowcnt_q + 1'b1) : '0;
         rpcnt_q <= !s_rstn ? (rp_done ? rpcnt_q : rpcnt_q + 1'b1) : '0;
         rhcnt_q <= s_rstn ? (rh_done ? rhcnt_q : rhcnt_q + 1'b1) : '0;
         if (s_low && pd_done) begin
            pd_met_q <= 1'b1;
         end else if (pwr_q == sfi_pkg::PWR_COLD) begin
            pd_met_q <= 1'b0;
         end
      end
   end

   // Next power state
   always_comb begin
      pwr_d = pwr_q;
      cnt_d = cnt_q;
      case (pwr_q)
         sfi_pkg::PWR_OFF: begin
            // Off until low long enough and supply back to minimum
            if (!s_low && s_min && pd_met_q) begin
               pwr_d = sfi_pkg::PWR_COLD;
               cnt_d = '0;
            end
         end
         sfi_pkg::PWR_LOWPROT: begin
            if (s_low) begin
               pwr_d = sfi_pkg::PWR_OFF;
            end else if (!s_cut && s_min) begin
               pwr_d = sfi_pkg::PWR_READY;
            end
         end
         sfi_pkg::PWR_COLD: begin
            // Silent for the whole power-up interval
            cnt_d = cnt_q + 1'b1;
            if (cnt_q >= PU_N - 1'b1) begin
               pwr_d = sfi_pkg::PWR_READY;
            end
         end
         sfi_pkg::PWR_WARM: begin
            // Processing interval and release hold must both pass
            if (cnt_q < RPH_N) begin
               cnt_d = cnt_q + 1'b1;
            end
            if (cnt_q >= RPH_N && s_rstn && rh_done) begin
               pwr_d = sfi_pkg::PWR_READY;
            end
         end
         default: begin
            if (!rp_done) begin
               pwr_d = sfi_pkg::PWR_READY;
            end else begin
               pwr_d = sfi_pkg::PWR_WARM;
               cnt_d = '0;
            end
         end
      endcase
      // Supply low overrides every state; cut-off overrides every state but off
      if (s_low) begin
         pwr_d = sfi_pkg::PWR_OFF;
      end else if (s_cut && pwr_q != sfi_pkg::PWR_OFF) begin
         pwr_d = sfi_pkg::PWR_LOWPROT;
      end
   end

   // Power state register
   always_ff @(posedge core_clk_i) begin
      if (!rst_n_i) begin
         pwr_q <= sfi_pkg::PWR_OFF;
         cnt_q <= '0;
      end else begin
         pwr_q <= pwr_d;
         cnt_q <= cnt_d;
      end
   end

   // Ready level crosses to the link domain; core outputs registered
   wire ready_core = (pwr_q == sfi_pkg::PWR_READY);
   always_ff @(posedge core_clk_i) begin
      if (!rst_n_i) begin
         cmd_enable_o <= 1'b0;
         pwr_state_o <= 3'h0;
      end else begin
         cmd_enable_o <= ready_core && sync2_q[4];
         pwr_state_o <= pwr_q;
      end
   end

   // Link domain: synchronise ready into sck
   logic rdy1_q;
   logic rdy2_q;
   always_ff @(posedge sck_i or posedge cs_n_i) begin
      if (cs_n_i) begin
         rdy1_q <= 1'b0;
         rdy2_q <= 1'b0;
      end else begin
         rdy1_q <= ready_core;
         rdy2_q <= rdy1_q;
      end
   end

   // Pause applies only when quad mode is off and not DDR
   wire quad_en = configuration_reg_i[`SFI_CFG_QUAD_BIT];
   wire paused = !quad_en && !dq_i[3] && !req_i.ddr;

   // Link phase machine, cleared by deselect
   sfi_pkg::sfi_phase_t ph_q;
   logic [2:0] bit_q;
   logic [7:0] sh_q;
   logic ddr_q;
   logic latdrv_q;
   always_ff @(posedge sck_i or posedge cs_n_i) begin
      if (cs_n_i) begin
         ph_q <= sfi_pkg::PH_STANDBY;
         bit_q <= 3'h0;
         sh_q <= 8'h00;
         instr_valid_o <= 1'b0;
         ddr_q <= 1'b0;
         latdrv_q <= 1'b0;
      end else if (paused) begin
         ph_q <= ph_q;
      end else begin
         case (ph_q)
            sfi_pkg::PH_STANDBY: begin
               // First edge after select falls is instruction bit 7;
               // readiness only gates the valid flag, never the capture
               ph_q <= sfi_pkg::PH_INSTR;
               sh_q <= {7'h00, dq_i[0]};
               bit_q <= 3'h1;
            end
            sfi_pkg::PH_INSTR: begin
               // Freeze the captured byte once all eight bits are in and it is flagged valid
               if (!instr_valid_o) begin
                  sh_q <= {sh_q[6:0], dq_i[0]};
               end
               bit_q <= bit_q + 3'h1;
               if (bit_q == 3'h7) begin
                  instr_valid_o <= rdy2_q;
               end
               if (req_valid_i && instr_valid_o) begin
                  ph_q <= sfi_pkg::sfi_phase_t'(req_i.phase);
                  ddr_q <= req_i.ddr;
                  latdrv_q <= req_i.lat_drive;
               end
            end
            default: begin
               if (req_valid_i) begin
                  ph_q <= sfi_pkg::sfi_phase_t'(req_i.phase);
                  ddr_q <= req_i.ddr;
                  latdrv_q <= req_i.lat_drive;
               end
            end
         endcase
      end
   end
   assign instr_o = sh_q;
   assign phase_o = ph_q;
   // Latency code, registered so the output comes from a flop
   always_ff @(posedge core_clk_i) begin
      if (!rst_n_i) begin
         lat_code_o <= 2'h0;
      end else begin
         lat_code_o <=
            configuration_reg_i[`SFI_CFG_LAT_MSB:`SFI_CFG_LAT_LSB];
      end
   end

   // Output enables per phase; input phases never drive
   logic [3:0] oe_w;
   always_comb begin
      case (ph_q)
         sfi_pkg::PH_OUT_SINGLE: oe_w = 4'h2;
         sfi_pkg::PH_OUT_DUAL: oe_w = 4'h3;
         sfi_pkg::PH_OUT_QUAD: oe_w = 4'hf;
         // Only DDR latency may drive; SDR latency floats
         sfi_pkg::PH_LATENCY:
            oe_w = (ddr_q && latdrv_q) ? 4'hf : 4'h0;
         // Input phases: line use set on host side
         default: oe_w = 4'h0;
      endcase
   end

   // Drive on falling sck edge; float when paused or deselected
   always_ff @(negedge sck_i or posedge cs_n_i) begin
      if (cs_n_i) begin
         dq_oe_o <= 4'h0;
         dq_o <= 4'h0;
      end else begin
         dq_oe_o <= (paused || !rdy2_q) ? 4'h0 : oe_w;
         dq_o <= (ph_q == sfi_pkg::PH_OUT_SINGLE) ?
            {2'b00, rd_nib_i[0], 1'b0} : rd_nib_i;
      end
   end
endmodule : sfi_iface
`default_nettype wire

/* tb/sfi_iface_monitor.sv */
// Checker for the flash interface state block
`timescale 1ns/1ps
`default_nettype none
module sfi_iface_monitor #(
   parameter int PU_CYC = 20
) (
   // Clocks and resets
   input wire logic core_clk_i,
   input wire logic rst_n_i,
   input wire logic sck_i,
   input wire logic cs_n_i,
   // Watched lines
   input wire logic [3:0] dq_i,
   input wire logic [3:0] dq_oe_o,
   input wire logic [7:0] configuration_reg_i,
   input wire logic cmd_enable_o,
   input wire logic [2:0] pwr_state_o,
   input wire logic [3:0] phase_o,
   input wire logic [1:0] lat_code_o
);
   logic [15:0] cold_q;  // Cycles spent in cold reset
   // Count cold reset cycles
   always_ff @(posedge core_clk_i) begin
      if (pwr_state_o != 3'h2) cold_q <= 16'h0;
      else cold_q <= cold_q + 16'h1;
   end
   off_float_a: assert property (
      @(posedge core_clk_i) disable iff (!rst_n_i) pwr_state_o inside {3'h0, 3'h2}
      |-> dq_oe_o == 4'h0) else $error("drive while off or in cold reset");
   lowprot_block_a: assert property (
      @(posedge core_clk_i) disable iff (!rst_n_i) pwr_state_o == 3'h1 &&
      $past(pwr_state_o) == 3'h1 |-> !cmd_enable_o) else $error("commands open");
   cold_len_a: assert property (
      @(posedge core_clk_i) disable iff (!rst_n_i) $past(pwr_state_o) == 3'h2
      && pwr_state_o == 3'h4 |-> cold_q >= PU_CYC - 1 && cold_q <= PU_CYC + 2)
      else $error("cold reset length wrong");
   warm_block_a: assert property (
      @(posedge core_clk_i) disable iff (!rst_n_i) pwr_state_o == 3'h3 &&
      $past(pwr_state_o) == 3'h3 |-> !cmd_enable_o) else $error("warm open");
   desel_float_a: assert property (
      @(posedge core_clk_i) disable iff (!rst_n_i) cs_n_i && $past(cs_n_i)
      |-> dq_oe_o == 4'h0) else $error("drive while deselected");
   lat_code_a: assert property (
      @(posedge core_clk_i) disable iff (!rst_n_i)
      lat_code_o == $past(configuration_reg_i[7:6])) else $error("latency code");
   out_drive_a: assert property (
      @(posedge sck_i) disable iff (cs_n_i) phase_o inside {4'h7, 4'h8, 4'h9}
      && $stable(phase_o) && (configuration_reg_i[1] || (dq_i[3] &&
      $past(dq_i[3]))) |-> dq_oe_o == (phase_o == 4'h7 ? 4'h2 :
      phase_o == 4'h8 ? 4'h3 : 4'hf)) else $error("output lines wrong");
   in_quiet_a: assert property (
      @(posedge sck_i) disable iff (cs_n_i) phase_o inside {[4'h2:4'h5]}
      && $stable(phase_o) |-> dq_oe_o == 4'h0) else $error("drive on input");
   pause_a: assert property (
      @(posedge sck_i) disable iff (cs_n_i) !configuration_reg_i[1] &&
      !dq_i[3] && !$past(dq_i[3]) |-> dq_oe_o == 4'h0 && $stable(phase_o))
      else $error("pause not honoured");
endmodule : sfi_iface_monitor
bind sfi_iface sfi_iface_monitor #(.PU_CYC(PU_CYC)) mon (
   .core_clk_i(core_clk_i), .rst_n_i(rst_n_i), .sck_i(sck_i),
   .cs_n_i(cs_n_i), .dq_i(dq_i), .dq_oe_o(dq_oe_o),
   .configuration_reg_i(configuration_reg_i), .cmd_enable_o(cmd_enable_o),
   .pwr_state_o(pwr_state_o), .phase_o(phase_o), .lat_code_o(lat_code_o));
`default_nettype wire

/* tb/sfi_host_model.sv */
// Host controller model: link clock, select, data lines, phase request
`timescale 1ns/1ps
`default_nettype none
module sfi_host_model (
   // Link toward the device
   output var logic sck_o,
   output var logic cs_n_o,
   output var logic [3:0] dq_o,
   output var sfi_pkg::sfi_req_t req_o,
   output var logic req_valid_o
);
   // Idle: clock low, deselected
   initial begin
      sck_o = 1'b0;
      cs_n_o = 1'b1;
      dq_o = 4'h5;
      req_o = '0;
      req_valid_o = 1'b0;
   end
   // One link cycle: data set while clock low, 30 ns period
   task automatic cyc(input logic [3:0] v);
      dq_o = v;
      #15 sck_o = 1'b1;
      #15 sck_o = 1'b0;
   endtask : cyc
   // Select and send eight instruction bits, top bit first
   task automatic instr(input logic [7:0] op);
      cs_n_o = 1'b0;
      for (int i = 7; i >= 0; i--) cyc({1'b1, 2'($urandom), op[i]});
   endtask : instr
   // Cycles with pause line high; other lines valid or don't-care
   task automatic run(input int n);
      repeat (n) cyc({1'b1, 3'($urandom)});
   endtask : run
   // Hand the decoder's next phase over one rising edge
   task automatic req_phase(input logic [3:0] ph, input logic ddr,
      input logic ld);
      req_o = {ph, ddr, ld};
      req_valid_o = 1'b1;
      run(1);
      req_valid_o = 1'b0;
   endtask : req_phase
   // Deselect; released lines show the inverse of the last value
   task automatic stop;
      cs_n_o = 1'b1;
      dq_o = ~dq_o;
   endtask : stop
endmodule : sfi_host_model
`default_nettype wire

/* tb/test_spi_flash_interface_states.sv */
// Self-checking bench for the flash interface state block
`timescale 1ns/1ps
`default_nettype none
module test_spi_flash_interface_states;
   logic core_clk_i, rst_n_i, vlow, vcut, vmin, hw_rst_n, sck, cs_n, req_v;
   logic ivalid, cmd_en, ddr, ld;
   logic [3:0] e;
   logic [7:0] cfg, instr, op;
   logic [3:0] rd_nib, dq_do, dq_oe, dq_h, phase;
   logic [2:0] pwr;
   logic [1:0] lat;
   sfi_pkg::sfi_req_t req;
   int err_count = 0, checks_done = 0, cyc_cnt = 0, n;
   wire logic [3:0] dq = (dq_oe & dq_do) | (~dq_oe & dq_h);
   logic [3:0] tbl [7] = '{sfi_pkg::PH_OUT_SINGLE, sfi_pkg::PH_OUT_DUAL,
      sfi_pkg::PH_OUT_QUAD, sfi_pkg::PH_IN_SINGLE, sfi_pkg::PH_IN_DUAL,
      sfi_pkg::PH_QPP_ADDR, sfi_pkg::PH_LATENCY};
   sfi_iface #(.PU_CYC(20), .PD_CYC(20), .RPH_CYC(20)) dut (
      .core_clk_i(core_clk_i), .rst_n_i(rst_n_i), .vcc_low_i(vlow),
      .vcc_cutoff_i(vcut), .vcc_min_i(vmin), .hw_rst_n_i(hw_rst_n),
      .sck_i(sck), .cs_n_i(cs_n), .dq_i(dq), .dq_o(dq_do), .dq_oe_o(dq_oe),
      .configuration_reg_i(cfg), .req_i(req), .req_valid_i(req_v),
      .rd_nib_i(rd_nib), .instr_o(instr), .instr_valid_o(ivalid),
      .cmd_enable_o(cmd_en), .pwr_state_o(pwr), .phase_o(phase),
      .lat_code_o(lat));
   sfi_host_model host (.sck_o(sck), .cs_n_o(cs_n), .dq_o(dq_h), .req_o(req),
      .req_valid_o(req_v));
   // Compare one value and count it
   task automatic check(input string what, input logic [7:0] got, exp);
      checks_done++;
      if (got !== exp) begin
         err_count++;
         $display("MISMATCH %s expected %h seen %h", what, exp, got);
      end
   endtask : check
   // Counts and verdict, then stop
   task automatic conclude;
      $display("checks %0d mismatches %0d", checks_done, err_count);
      if (err_count == 0 && checks_done > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask : conclude
   // Let core cycles pass; inputs move 1 ns after the edge
   task automatic core(input int k);
      repeat (k) @(posedge core_clk_i);
      #1;
   endtask : core
   // Bounded wait for a power state
   task automatic wait_pwr(input logic [2:0] s, input int lim, output int c);
      c = 0;
      while (pwr !== s && c < lim) begin
         core(1);
         c++;
      end
   endtask : wait_pwr
   // Lines the device drives in each phase
   function automatic logic [3:0] exp_oe(input logic [3:0] ph, input logic dl);
      if (ph == sfi_pkg::PH_LATENCY && dl) return 4'hf;
      if (ph == sfi_pkg::PH_OUT_QUAD) return 4'hf;
      if (ph == sfi_pkg::PH_OUT_DUAL) return 4'h3;
      if (ph == sfi_pkg::PH_OUT_SINGLE) return 4'h2;
      return 4'h0;
   endfunction : exp_oe
   // Core clock, 8 ns
   initial begin
      core_clk_i = 1'b0;
      forever #4 core_clk_i = ~core_clk_i;
   end
   // Hang guard
   always @(posedge core_clk_i) begin
      cyc_cnt++;
      if (cyc_cnt == 20000) begin
         err_count++;
         conclude();
      end
   end
   initial begin
      {rst_n_i, vcut, vmin, hw_rst_n, vlow, cfg} = {4'h1, 1'b1, 8'h02};
      rd_nib = 4'($urandom(66));
      core(3);
      rst_n_i = 1'b1;
      check("off", pwr, 3'h0);
      core(5);
      {vlow, vmin} = 2'b01;
      core(30);
      check("short low", pwr, 3'h0);
      {vlow, vmin} = 2'b10;
      core(25);
      {vlow, vmin} = 2'b01;
      wait_pwr(3'h2, 5, n);
      check("cold", pwr, 3'h2);
      wait_pwr(3'h4, 40, n);
      check("cold long", 8'(n >= 18), 8'h1);
      $display("power-up test done");
      hw_rst_n = 1'b0;
      core(3);
      hw_rst_n = 1'b1;
      core(40);
      check("short pulse", pwr, 3'h4);
      hw_rst_n = 1'b0;
      core(30);
      check("warm", pwr, 3'h3);
      hw_rst_n = 1'b1;
      wait_pwr(3'h4, 60, n);
      core(2);
      check("warm done", {n >= 5, cmd_en, pwr}, 5'h1c);
      $display("reset test done");
      foreach (tbl[i]) begin
         op = 8'($urandom);
         cfg = 8'($urandom) | 8'h02;
         rd_nib = 4'($urandom);
         host.instr(op);
         #2 check("instr", instr, op);
         {ddr, ld} = 2'($urandom);
         e = exp_oe(tbl[i], ddr && ld);
         host.req_phase(tbl[i], ddr, ld);
         host.run(2);
         #2 check("phase", {ivalid, phase}, {1'b1, tbl[i]});
         check("drive", dq_oe, e);
         check("data", dq_do & e, (tbl[i] == sfi_pkg::PH_OUT_SINGLE ?
            {2'b00, rd_nib[0], 1'b0} : rd_nib) & e);
         check("lat", lat, cfg[7:6]);
         host.stop();
         #20 check("deselect", dq_oe, 4'h0);
      end
      cfg = 8'h00;
      host.instr(op);
      host.req_phase(sfi_pkg::PH_OUT_SINGLE, 1'b0, 1'b0);
      host.run(2);
      host.cyc(4'h5);
      host.cyc(4'h2);
      #2 check("pause", {dq_oe, phase}, 8'h07);
      host.stop();
      $display("frame test done");
      vcut = 1'b1;
      core(5);
      check("cut-off", {cmd_en, pwr}, 4'h1);
      host.instr(op);
      host.run(2);
      #2 check("refused", ivalid, 1'b0);
      host.stop();
      vlow = 1'b1;
      core(5);
      check("off again", {dq_oe, 1'b0, pwr}, 8'h00);
      $display("supply test done");
      conclude();
   end
endmodule : test_spi_flash_interface_states
`default_nettype wire
